// ==== blc_pkg.sv ====
/*
 black level calibration package: register indices, field positions,
 reset values and shared types.
 assumes a 16-bit configuration word interface with 9-bit indices.
*/
package blc_pkg;
  // register indices (printed offsets are not multiples of four)
  localparam logic [8:0] BLC_IDX_FILTER  = 9'h080; // dark_sample_filter_config
  localparam logic [8:0] BLC_IDX_CORR    = 9'h081; // dark_level_correction_config
  localparam logic [8:0] BLC_IDX_ROWGEN  = 9'h0c5; // dark_row_generation_config
  localparam logic [8:0] BLC_IDX_STATUS  = 9'h088; // error status word
  localparam logic [8:0] BLC_IDX_SYNC    = 9'h0ce; // sync enables
  // field positions
  localparam int BLC_POS_SAMPLES   = 8;  // filter[10:8]
  localparam int BLC_POS_AUTO      = 0;  // corr[0]
  localparam int BLC_POS_OFFS      = 1;  // corr[9:1]
  localparam int BLC_POS_SIGN      = 10; // corr[10]
  localparam int BLC_POS_GATE      = 8;  // rowgen[9:8]
  localparam int BLC_POS_SYNC_ROWS = 1;  // sync[1]
  localparam int BLC_POS_ERR       = 0;  // status[0]
  // reset values, offset freeze code and pixel code maximum
  localparam logic [15:0] BLC_RST_FILTER = 16'h0300;
  localparam logic [15:0] BLC_RST_CORR   = 16'h0001;
  localparam logic [15:0] BLC_RST_ROWGEN = 16'h0108;
  localparam logic [15:0] BLC_RST_SYNC   = 16'h0002;
  localparam logic [8:0]  BLC_OFFS_FREEZE = 9'h1ff;
  localparam logic [9:0]  BLC_PIX_MAX     = 10'h3ff;
  // register access request
  typedef struct packed {
    logic       wr;    // write strobe
    logic [8:0] idx;   // register index
    logic [15:0] data; // write data
  } blc_req_t;
  // pixel stream beat
  typedef struct packed {
    logic       valid; // beat present
    logic       sol;   // first pixel of a row
    logic [9:0] pix;   // pixel code
  } blc_pix_t;
endpackage

// ==== blc_calib.sv ====
/*
 black level calibration: black row generation, black sample filtering,
 auto or manual offset correction with saturation.
 assumes a frame start pulse, a row end pulse and a pixel stream on
 i_ref_clk; configuration writes come from a same-clock register port.
*/
`timescale 1ns/100ps
//
// Contract
// - generate black row count rows each frame
// - black rows last one active row
// - skip setting blanks first black rows; code blanks only the first black row for any non-zero setting
// - auto mode applies computed offset
// - manual mode applies manual offset
// - black pixels leave uncorrected
// - sign zero adds, one subtracts
// - sign ignored in auto mode
// - one common offset for all channels
// - offset all ones freezes auto factors
// - recompute factors once per frame
// - filter two to samples-field black samples
// - flag error when samples exceed available; code flags it in auto mode only
// - row count updates only when synced
module blc_calib
  import blc_pkg::*;
(
  input  wire logic        i_ref_clk,   // sensor logic clock
  input  wire logic        i_rst_b,     // async reset, active low
  input  wire blc_req_t    i_req,       // register access
  output logic [15:0]      o_rdata,     // read data for i_req.idx
  input  wire logic        i_frame_sof, // frame start pulse
  input  wire logic        i_row_end,   // end of a row (window length)
  input  wire blc_pix_t    i_pix,       // raw pixel stream
  output blc_pix_t         o_pix,       // corrected pixel stream
  output logic             o_black_row, // current row is a black row
  output logic             o_blank      // current row is blanked
);

  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [15:0] cfg_filter;      // sample count word
  logic [15:0] cfg_corr;        // correction word
  logic [15:0] cfg_rowgen;      // row generation word (shadow)
  logic [15:0] cfg_sync;        // sync enables
  logic        err_samples;     // sticky sample shortage flag
  logic [15:0] next_filter;
  logic [15:0] next_corr;
  logic [15:0] next_rowgen;
  logic [15:0] next_sync;
  logic        next_err;
  logic        err_set;         // shortage seen this frame

  // write decode and sticky error, set beats clear
  always_comb begin
    next_filter = cfg_filter;
    next_corr   = cfg_corr;
    next_rowgen = cfg_rowgen;
    next_sync   = cfg_sync;
    next_err    = err_samples;
    if (i_req.wr) begin
      case (i_req.idx)
        BLC_IDX_FILTER: next_filter = i_req.data;
        BLC_IDX_CORR:   next_corr   = i_req.data;
        BLC_IDX_ROWGEN: next_rowgen = i_req.data;
        BLC_IDX_SYNC:   next_sync   = i_req.data;
        BLC_IDX_STATUS: next_err    = 1'b0; // write clears
        default: ;
      endcase
    end
    if (err_set) begin
      next_err = 1'b1;
    end
  end

  // register storage
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_filter  <= BLC_RST_FILTER;
      cfg_corr    <= BLC_RST_CORR;
      cfg_rowgen  <= BLC_RST_ROWGEN;
      cfg_sync    <= BLC_RST_SYNC;
      err_samples <= 1'b0;
    end else begin
      cfg_filter  <= next_filter;
      cfg_corr    <= next_corr;
      cfg_rowgen  <= next_rowgen;
      cfg_sync    <= next_sync;
      err_samples <= next_err;
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    case (i_req.idx)
      BLC_IDX_FILTER: o_rdata = cfg_filter;
      BLC_IDX_CORR:   o_rdata = cfg_corr;
      BLC_IDX_ROWGEN: o_rdata = cfg_rowgen;
      BLC_IDX_SYNC:   o_rdata = cfg_sync;
      BLC_IDX_STATUS: o_rdata = {15'h0000, err_samples};
      default:        o_rdata = 16'h0000;
    endcase
  end

  // field views
  logic [2:0] f_samples;
  logic       f_auto;
  logic [8:0] f_offs;
  logic       f_sign;
  logic       f_freeze;
  assign f_samples = cfg_filter[BLC_POS_SAMPLES +: 3];
  assign f_auto    = cfg_corr[BLC_POS_AUTO];
  assign f_offs    = cfg_corr[BLC_POS_OFFS +: 9];
  assign f_sign    = cfg_corr[BLC_POS_SIGN];
  assign f_freeze  = f_auto && (f_offs == BLC_OFFS_FREEZE);

  ////////////////////////////////////////////////////////////////////////
  // row sequencing
  logic [7:0] act_rows;      // active black row count
  logic       act_gate;      // active skip setting
  logic [7:0] row_cnt;       // black rows done this frame
  logic       in_black;      // inside black rows
  logic [7:0] next_act_rows;
  logic       next_act_gate;
  logic [7:0] next_row_cnt;
  logic       next_in_black;

  // latch shadow at frame start when sync on; count black rows
  always_comb begin
    next_act_rows = act_rows;
    next_act_gate = act_gate;
    next_row_cnt  = row_cnt;
    next_in_black = in_black;
    if (i_frame_sof) begin
      if (cfg_sync[BLC_POS_SYNC_ROWS]) begin
        next_act_rows = cfg_rowgen[7:0];
        next_act_gate = |cfg_rowgen[BLC_POS_GATE +: 2];
      end
      next_row_cnt  = 8'h00;
      next_in_black = 1'b1;
    end else if (in_black && i_row_end) begin
      // a black row ends on the window row length
      next_row_cnt = row_cnt + 8'h01;
      if (row_cnt + 8'h01 >= act_rows) begin
        next_in_black = 1'b0;
      end
    end
  end

  // row state registers
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      act_rows <= BLC_RST_ROWGEN[7:0];
      act_gate <= 1'b1;
      row_cnt  <= 8'h00;
      in_black <= 1'b0;
    end else begin
      act_rows <= next_act_rows;
      act_gate <= next_act_gate;
      row_cnt  <= next_row_cnt;
      in_black <= next_in_black;
    end
  end

  logic gated_row; // first black row blanked
  assign gated_row   = in_black && act_gate && (row_cnt == 8'h00);
  assign o_black_row = in_black;
  assign o_blank     = gated_row;

  ////////////////////////////////////////////////////////////////////////
  // black sample accumulation
  logic [17:0] acc;        // sample sum, up to 128 x 10 bits
  logic [7:0]  acc_n;      // samples taken (stops at need, 128 at most)
  logic [9:0]  level;      // computed black level
  logic [9:0]  next_level;
  logic [17:0] next_acc;
  logic [7:0]  next_acc_n;
  logic [7:0]  need;       // 2^samples
  logic        use_sample;
  logic [2:0]  act_samples;      // sample count exponent in force this frame
  logic [2:0]  next_act_samples;

  // two to the power of a 3-bit field
  function automatic logic [7:0] pow2(input logic [2:0] e);
    pow2 = 8'h01 << e;
  endfunction

  // the frame's own count caps the sum and divides it, so a count written
  // mid frame cannot scale an average taken under the old count
  assign need       = pow2(act_samples);
  assign use_sample = i_pix.valid && in_black && !gated_row && (acc_n < need);

  // sum first 2^n samples; at frame start take average in auto mode unless frozen or short
  always_comb begin
    next_acc   = acc;
    next_acc_n = acc_n;
    next_level = level;
    next_act_samples = act_samples;
    err_set    = 1'b0;
    if (i_frame_sof) begin
      if (acc_n >= need) begin
        if (f_auto && !f_freeze) begin
          next_level = 10'(acc >> act_samples);
        end
      end else begin
        err_set = f_auto;
      end
      next_acc   = 18'h00000;
      next_acc_n = 8'h00;
      next_act_samples = f_samples;
    end else if (use_sample) begin
      next_acc   = acc + 18'(i_pix.pix);
      next_acc_n = acc_n + 8'h01;
    end
  end

  // accumulator registers
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc   <= 18'h00000;
      acc_n <= 8'h00;
      level <= 10'h000;
      act_samples <= BLC_RST_FILTER[BLC_POS_SAMPLES +: 3];
    end else begin
      acc   <= next_acc;
      acc_n <= next_acc_n;
      level <= next_level;
      act_samples <= next_act_samples;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // correction
  logic [10:0] offs_mag;  // offset magnitude
  logic        offs_sub;  // subtract offset
  blc_pix_t    next_pix;

  // saturating apply of an offset
  function automatic logic [9:0] sat_apply(input logic [9:0] p,
                                           input logic [10:0] m,
                                           input logic sub);
    logic [11:0] s;
    s = 12'h000;
    if (sub) begin
      s = {2'b00, p} - {1'b0, m};
      sat_apply = s[11] ? 10'h000 : s[9:0];
    end else begin
      s = {2'b00, p} + {1'b0, m};
      sat_apply = (s > {2'b00, BLC_PIX_MAX}) ? BLC_PIX_MAX : s[9:0];
    end
  endfunction

  // auto subtracts level ignoring sign; manual uses common signed offset
  always_comb begin
    if (f_auto) begin
      offs_mag = {1'b0, level};
      offs_sub = 1'b1;
    end else begin
      offs_mag = {2'b00, f_offs};
      offs_sub = f_sign;
    end
    next_pix.valid = i_pix.valid && !gated_row;
    next_pix.sol   = i_pix.sol;
    if (in_black) begin
      next_pix.pix = i_pix.pix;
    end else begin
      next_pix.pix = sat_apply(i_pix.pix, offs_mag, offs_sub);
    end
  end

  // output stage register
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pix <= '0;
    end else begin
      o_pix <= next_pix;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_black_raw: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_pix.valid && in_black && !gated_row) |=> (o_pix.valid && o_pix.pix == $past(i_pix.pix)))
    else $error("black pixel altered");
  a_gate_blank: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    gated_row |=> !o_pix.valid)
    else $error("gated row not blanked");
  a_manual_add: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_pix.valid && !in_black && !f_auto && !f_sign
     && ({2'b00, i_pix.pix} + {3'b000, f_offs}) <= 12'h3ff)
    |=> o_pix.pix == $past(i_pix.pix) + 10'($past(f_offs)))
    else $error("manual add wrong");
  a_sat_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_pix.valid && !in_black && !f_auto && f_sign && ({1'b0, i_pix.pix} < {2'b00, f_offs}))
    |=> o_pix.pix == 10'h000)
    else $error("no low saturation");
  a_freeze_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    f_freeze |=> $stable(level))
    else $error("frozen level moved");
  a_rows_sync: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_frame_sof && !cfg_sync[BLC_POS_SYNC_ROWS]) |=> $stable(act_rows))
    else $error("row count taken unsynced");
  a_black_start: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_frame_sof |=> (in_black && row_cnt == 8'h00))
    else $error("black rows not started");
  a_err_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_frame_sof && f_auto && acc_n < need) |=> err_samples)
    else $error("shortage not flagged");

endmodule // blc_calib

// ==== blc_host_model.sv ====
/*
 far side model: frame start, rows of pixel beats, row end pulses.
 assumes blc_pkg and a bench that calls send_frame between frames.
*/
`timescale 1ns/100ps
module blc_host_model
  import blc_pkg::*;
(
  input  wire logic i_ref_clk,   // logic clock
  output logic      o_frame_sof, // frame start pulse
  output logic      o_row_end,   // row end pulse
  output blc_pix_t  o_pix        // pixel beat
);
  // idle levels at time zero
  initial begin
    o_frame_sof = 1'b0;
    o_row_end = 1'b0;
    o_pix = '0;
  end
  ////////////////////////////////////////////////////////////////
  // one frame: bk rows of bv, then rows of iv, every row len beats
  task automatic send_frame(input int bk, input int tot, input int len,
                            input logic [9:0] bv, input logic [9:0] iv);
    @(negedge i_ref_clk) o_frame_sof = 1'b1;
    @(negedge i_ref_clk) o_frame_sof = 1'b0;
    for (int r = 0; r < tot; r++) begin
      for (int c = 0; c < len; c++) begin
        o_pix = '{1'b1, c == 0, (r < bk) ? bv : iv};
        @(negedge i_ref_clk);
      end
      // released beat shows the inverse of the last code
      o_pix = '{1'b0, 1'b0, ~o_pix.pix};
      o_row_end = 1'b1;
      @(negedge i_ref_clk) o_row_end = 1'b0;
    end
  endtask
endmodule // blc_host_model

// ==== test_black_level_calibration.sv ====
/*
 self-checking bench for blc_calib with a frame source model.
 assumes blc_pkg, blc_calib and blc_host_model are compiled first.
*/
`timescale 1ns/100ps
module test_black_level_calibration;
  import blc_pkg::*;
  localparam int LEN = 4;  // beats per row
  logic        i_ref_clk;  // 40 MHz clock
  logic        i_rst_b;    // reset, active low
  blc_req_t    i_req;      // register port
  logic [15:0] o_rdata;    // read data
  logic        i_frame_sof, i_row_end;
  blc_pix_t    i_pix, o_pix;
  logic        o_black_row, o_blank; // row status flags
  int          errors = 0, tests_run = 0;
  // expected state
  int          exp_rows = 8, cfg_rows = 8, prev_n = 0, row = 0, exp_n = 3, prev_need = 8;
  logic        exp_gate = 1, cfg_gate = 1, exp_auto = 1, exp_sign = 0;
  logic        exp_err = 0, sync_rows = 1;
  logic [8:0]  exp_offs = '0;
  logic [9:0]  exp_level = '0, prev_bv = '0, cap_pix;
  logic        cap_valid = 0, cap_black, cap_gated, cap_sol;

  blc_calib blc_calib_inst (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_req(i_req),
    .o_rdata(o_rdata), .i_frame_sof(i_frame_sof), .i_row_end(i_row_end), .i_pix(i_pix),
    .o_pix(o_pix), .o_black_row(o_black_row), .o_blank(o_blank));
  blc_host_model blc_host_model_inst (.i_ref_clk(i_ref_clk), .o_frame_sof(i_frame_sof),
    .o_row_end(i_row_end), .o_pix(i_pix));

  initial i_ref_clk = 1'b0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp16(input string what, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_beat(input logic ev, input logic es, input logic [9:0] ep,
                          input blc_pix_t g);
    tests_run++;
    if (g.valid !== ev || (ev && (g.sol !== es || g.pix !== ep))) begin
      errors++;
      $display("Error o_pix expected %b %b %h seen %b %b %h", ev, es, ep, g.valid, g.sol, g.pix);
    end
  endtask
  task automatic cmp_bit(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask
  // black beats pass raw; others corrected with clipping to the code range
  function automatic logic [9:0] corr(input logic blk, input logic [9:0] p);
    int v;
    if (blk) v = int'(p);
    else if (exp_auto) v = int'(p) - int'(exp_level);
    else if (exp_sign) v = int'(p) - int'(exp_offs);
    else v = int'(p) + int'(exp_offs);
    return (v < 0) ? 10'h000 : (v > 32'h3ff) ? 10'h3ff : v[9:0];
  endfunction
  task automatic wr(input logic [8:0] idx, input logic [15:0] d);
    @(negedge i_ref_clk);
    i_req = '{1'b1, idx, d};
    @(negedge i_ref_clk);
    i_req.wr = 1'b0;
    case (idx)
      BLC_IDX_CORR: {exp_sign, exp_offs, exp_auto} = d[10:0];
      BLC_IDX_FILTER: exp_n = d[10:8];
      BLC_IDX_ROWGEN: begin
        cfg_rows = d[7:0];
        cfg_gate = |d[9:8];
      end
      BLC_IDX_SYNC: sync_rows = d[1];
      BLC_IDX_STATUS: exp_err = 1'b0;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [8:0] idx, input logic [15:0] e);
    @(negedge i_ref_clk);
    i_req.idx = idx;
    #2 cmp16("o_rdata", e, o_rdata);
  endtask
  // frame start bookkeeping, then the frame itself
  task automatic run_frame(input int tot, input logic [9:0] bv, input logic [9:0] iv);
    if (exp_auto && prev_n >= prev_need && exp_offs != 9'h1ff) exp_level = prev_bv;
    if (exp_auto && prev_n < prev_need) exp_err = 1'b1;
    prev_need = 1 << exp_n; // count in force for the coming frame
    if (sync_rows) begin
      exp_rows = cfg_rows;
      exp_gate = cfg_gate;
    end
    prev_n = (exp_rows - int'(exp_gate)) * LEN;
    prev_bv = bv;
    blc_host_model_inst.send_frame(exp_rows, tot, LEN, bv, iv);
  endtask
  ////////////////////////////////////////////////////////////////
  // beat monitor: capture input beat and row, judge output next cycle
  always @(posedge i_ref_clk) begin
    if (i_frame_sof) row <= 0;
    else if (i_row_end) row <= row + 1;
    cap_valid <= i_pix.valid;
    cap_pix <= i_pix.pix;
    cap_sol <= i_pix.sol;
    cap_black <= row < exp_rows;
    cap_gated <= exp_gate && row == 0;
  end
  always @(negedge i_ref_clk)
    if (cap_valid === 1'b1) begin
      cmp_beat(!cap_gated, cap_sol, corr(cap_black, cap_pix), o_pix);
      cmp_bit("o_black_row", cap_black, o_black_row);
      cmp_bit("o_blank", cap_gated, o_blank);
    end
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [8:0] ix[6] = '{BLC_IDX_FILTER, BLC_IDX_CORR, BLC_IDX_ROWGEN, BLC_IDX_SYNC,
                          BLC_IDX_STATUS, 9'h100};
    logic [15:0] ev[6] = '{16'h0300, 16'h0001, 16'h0108, 16'h0002, 16'h0000, 16'h0000};
    for (int k = 0; k < 6; k++) rd(ix[k], ev[k]);
  endtask
  task automatic t_manual();
    logic       sg[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [8:0] of[4] = '{9'h005, 9'h100, 9'h010, 9'h1ff};
    logic [9:0] iv[4] = '{10'h100, 10'h3f0, 10'h008, 10'h3ff};
    wr(BLC_IDX_ROWGEN, 16'h0002);
    for (int k = 0; k < 4; k++) begin
      wr(BLC_IDX_CORR, {5'h00, sg[k], of[k], 1'b0});
      run_frame(4, 10'h123, iv[k]);
    end
  endtask
  task automatic t_gate();
    wr(BLC_IDX_CORR, 16'h0001);
    wr(BLC_IDX_ROWGEN, 16'h0102);
    repeat (2) run_frame(4, 10'h020, 10'h100);
    wr(BLC_IDX_ROWGEN, 16'h0103);
    repeat (2) run_frame(5, 10'h020, 10'h100);
  endtask
  task automatic t_auto();
    wr(BLC_IDX_FILTER, 16'h0200);
    wr(BLC_IDX_CORR, 16'h0401);
    repeat (2) run_frame(5, 10'h030, 10'h100);
    wr(BLC_IDX_CORR, 16'h07ff);
    repeat (2) run_frame(5, 10'h050, 10'h100);
    wr(BLC_IDX_CORR, 16'h0001);
    run_frame(5, 10'h050, 10'h020);
  endtask
  task automatic t_error();
    wr(BLC_IDX_STATUS, 16'h0000);
    rd(BLC_IDX_STATUS, 16'h0000);
    wr(BLC_IDX_FILTER, 16'h0700);
    repeat (2) run_frame(5, 10'h050, 10'h100);
    rd(BLC_IDX_STATUS, {15'h0000, exp_err});
    wr(BLC_IDX_STATUS, 16'h0000);
    rd(BLC_IDX_STATUS, 16'h0000);
  endtask
  task automatic t_sync();
    wr(BLC_IDX_SYNC, 16'h0000);
    wr(BLC_IDX_ROWGEN, 16'h0005);
    run_frame(7, 10'h050, 10'h100);
    wr(BLC_IDX_SYNC, 16'h0002);
    run_frame(7, 10'h050, 10'h100);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    i_rst_b = 1'b0;
    i_req = '0;
    repeat (16) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    t_reset();
    t_manual();
    t_gate();
    t_auto();
    t_error();
    t_sync();
    final_report();
  end
  // watchdog: the run needs well under 20000 cycles
  initial begin
    #500000;
    errors++;
    final_report();
  end
endmodule // test_black_level_calibration
